// *** ovp_params.svh ***
/*
  Constants of the output-voltage protection register bank: command codes,
  page codes, fixed register values and reset values.
  Assumes inclusion by its bare name from the design and bench files.
*/
`ifndef OVP_PARAMS_SVH
`define OVP_PARAMS_SVH

// command codes on the management link
`define CMD_PAGE       8'h00
`define CMD_CEIL       8'h24
`define CMD_OV_TRIP    8'h40
`define CMD_OV_REACT   8'h41
`define CMD_UV_TRIP    8'h44

// page codes
`define PAGE_A         8'h00
`define PAGE_B         8'h01
`define PAGE_ALL       8'hff

// fixed and reset values
`define OV_REACT_CODE  8'h80
`define OV_TRIP_5MV    8'hff
`define CEIL_RESET     8'hff
`define UV_RESET       8'h00
`define PAGE_RESET     8'h00

// request word: {write, command, data}
`define REQ_W          25
`define RSP_W          16

`endif

// *** ovp_pkg.sv ***
/*
  Types shared by the protection register bank.
  Assumes ovp_params.svh is visible on the include path.
*/
package ovp_pkg;

  // one-hot states of the link engine
  typedef enum logic [7:0] {
    L_IDLE  = 8'h01,
    L_ADDR  = 8'h02,
    L_CMD   = 8'h04,
    L_WDATA = 8'h08,
    L_ACK   = 8'h10,
    L_RDATA = 8'h20,
    L_RACK  = 8'h40,
    L_WAIT  = 8'h80
  } link_state_t;

endpackage : ovp_pkg

// *** ovp_regs.sv ***
/*
  Output-voltage protection register bank of a dual-channel converter controller,
  reached over the two-wire management link (clock and data pins, open drain).
  Assumes: link_clk_i free-running and much faster than the link's bit clock;
  fault comparators, enable pins are asynchronous; targets, droop, masks, clears
  and the on bits come from logic on mclk_i.
*/
// Function
// - with the 5 mV step table, overvoltage trip level reads all ones
// - with the 10 mV table, overvoltage trip is ceiling plus fixed offset
// - overvoltage trip register is 16 bits, upper byte zero, lower read-only
// - overvoltage reaction byte is read-only and returns the latch-off code
// - overvoltage reaction is one shared instance, page value ignored
// - overvoltage fault latches channel off and sets its three status bits
// - set status raises host alert unless its mask bit is set
// - page 00h selects channel A, 01h channel B, FFh both
// - ceiling register 16 bits, upper byte zero, lower byte read-write
// - a commanded target above the ceiling is clamped to the ceiling
// - ceiling check covers the commanded target loads on target_load_i
// - ceiling violation is a warning: other, vout and min/max bits set
// - undervoltage trip derives from target less droop less fixed offset
// - ceiling and overvoltage trip default 1.520 V, undervoltage 0.000 V
// - undervoltage trip register holds read-only level in lower byte
// - undervoltage fault sets other, vout and undervoltage status bits
`timescale 1ns/1ns
`include "ovp_params.svh"
module ovp_regs
  import ovp_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR  = 7'h2a,  // arbitrary
  parameter int         VID_W     = 8,
  parameter logic [7:0] OV_OFFSET = 8'h0a,
  parameter logic [7:0] UV_OFFSET = 8'h0a
) (
  // clocks and reset
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  input  wire logic       link_clk_i,
  // management link pins
  input  wire logic       pmb_scl_i,
  output logic            pmb_scl_o,
  output logic            pmb_scl_oe_o,
  input  wire logic       pmb_sda_i,
  output logic            pmb_sda_o,
  output logic            pmb_sda_oe_o,
  output logic            host_alert_n_o,
  // converter side, channel A in bit 0
  input  wire logic       dac_step_5mv_i,
  input  wire logic [7:0] target_code_a_i,
  input  wire logic [7:0] target_code_b_i,
  input  wire logic [1:0] target_load_i,
  input  wire logic [7:0] droop_code_a_i,
  input  wire logic [7:0] droop_code_b_i,
  input  wire logic [1:0] ov_fault_i,
  input  wire logic [1:0] uv_fault_i,
  input  wire logic [1:0] channel_enable_pin_i,
  input  wire logic [1:0] operation_on_i,
  // status handling
  input  wire logic [1:0] status_clear_i,
  input  wire logic       mask_ov_i,
  input  wire logic       mask_uv_i,
  input  wire logic       mask_warn_i,
  // results
  output logic      [7:0] applied_target_a_o,
  output logic      [7:0] applied_target_b_o,
  output logic      [1:0] channel_off_o,
  output logic      [1:0] stat_byte_ovf_o,
  output logic      [1:0] stat_byte_other_o,
  output logic      [1:0] stat_word_vout_o,
  output logic      [1:0] stat_vout_ov_o,
  output logic      [1:0] stat_vout_uv_o,
  output logic      [1:0] stat_vout_warn_o
);

  if (VID_W != 8) begin : g_width_check
    $error("ovp_regs serves 8-bit codes only");
  end

  function automatic logic [1:0] page_mask(input logic [7:0] p);
    page_mask = (p == `PAGE_A)   ? 2'b01 :
                (p == `PAGE_B)   ? 2'b10 :
                (p == `PAGE_ALL) ? 2'b11 : 2'b00;
  endfunction : page_mask

  function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s       = {1'b0, a} + {1'b0, b};
    sat_add = s[8] ? 8'hff : s[7:0];
  endfunction : sat_add

  function automatic logic [7:0] sat_sub(input logic [7:0] a, input logic [7:0] b);
    sat_sub = (a > b) ? a - b : 8'h00;
  endfunction : sat_sub

  // link-domain signals
  logic              lrst_n;
  logic              scl_s;
  logic              sda_s;
  logic              scl_d_q;
  logic              sda_d_q;
  link_state_t       st_q;
  link_state_t       nxt_q;
  logic [3:0]        bcnt_q;
  logic [7:0]        sh_q;
  logic              rw_q;
  logic              mack_q;
  logic [7:0]        cmd_q;
  logic [1:0]        nbyt_q;
  logic [15:0]       wdat_q;
  logic [1:0]        ridx_q;
  logic              rdv_q;
  logic [`RSP_W-1:0] rdat_q;
  logic              sda_oe_q;
  logic              scl_oe_q;
  logic              req_send_q;
  logic [`REQ_W-1:0] req_q;
  logic              rsp_v;
  logic [`RSP_W-1:0] rsp_word;

  sync_bits #(.W(3)) u_pin_sync (
    .clk_i (link_clk_i),
    .d_i   ({pmb_scl_i, pmb_sda_i, nrst_i}),
    .q_o   ({scl_s, sda_s, lrst_n})
  );

  wire scl_rise = scl_s & ~scl_d_q;
  wire scl_fall = ~scl_s & scl_d_q;
  wire start_w  = scl_s & scl_d_q & sda_d_q & ~sda_s;
  wire stop_w   = scl_s & scl_d_q & ~sda_d_q & sda_s;
  wire [7:0] tx_byte = (ridx_q == 2'd0) ? rdat_q[7:0] :
                       (ridx_q == 2'd1) ? rdat_q[15:8] : 8'h00;

  always_ff @(posedge link_clk_i) begin
    scl_d_q <= scl_s;
    sda_d_q <= sda_s;
  end

  // link engine; the read word is fetched at the command byte, scl held if late
  always_ff @(posedge link_clk_i) begin
    req_send_q <= 1'b0;
    if (!lrst_n) begin
      st_q     <= L_IDLE;
      nxt_q    <= L_IDLE;
      bcnt_q   <= '0;
      sh_q     <= '0;
      rw_q     <= 1'b0;
      mack_q   <= 1'b0;
      cmd_q    <= '0;
      nbyt_q   <= '0;
      wdat_q   <= '0;
      ridx_q   <= '0;
      rdv_q    <= 1'b0;
      rdat_q   <= '0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      req_q    <= '0;
    end else begin
      if (start_w) begin
        st_q     <= L_ADDR;
        bcnt_q   <= '0;
        nbyt_q   <= '0;
        ridx_q   <= '0;
        sda_oe_q <= 1'b0;
      end else if (stop_w) begin
        if (!rw_q && nbyt_q != 2'd0) begin
          req_send_q <= 1'b1;
          req_q      <= {1'b1, cmd_q, wdat_q};
        end
        st_q     <= L_IDLE;
        nbyt_q   <= '0;
        sda_oe_q <= 1'b0;
        scl_oe_q <= 1'b0;
      end else begin
        unique case (st_q)
          L_IDLE: ;
          L_ADDR, L_CMD, L_WDATA: begin
            if (scl_rise) begin
              sh_q   <= {sh_q[6:0], sda_s};
              bcnt_q <= bcnt_q + 4'd1;
            end else if (scl_fall && bcnt_q == 4'd8) begin
              sda_oe_q <= 1'b1;
              st_q     <= L_ACK;
              if (st_q == L_ADDR) begin
                rw_q  <= sh_q[0];
                nxt_q <= sh_q[0] ? L_RDATA : L_CMD;
                if (sh_q[7:1] != DEV_ADDR) begin
                  sda_oe_q <= 1'b0;
                  st_q     <= L_IDLE;
                end
              end else if (st_q == L_CMD) begin
                cmd_q      <= sh_q;
                nxt_q      <= L_WDATA;
                rdv_q      <= 1'b0;
                req_send_q <= 1'b1;
                req_q      <= {1'b0, sh_q, 16'h0000};
              end else begin
                nxt_q  <= L_WDATA;
                nbyt_q <= nbyt_q + {1'b0, nbyt_q != 2'd3};
                if (nbyt_q == 2'd0) wdat_q[7:0] <= sh_q;
                else if (nbyt_q == 2'd1) wdat_q[15:8] <= sh_q;
              end
            end
          end
          L_ACK: begin
            if (scl_fall) begin
              bcnt_q <= '0;
              if (nxt_q == L_RDATA && rdv_q) begin
                sda_oe_q <= ~tx_byte[7];
                sh_q     <= {tx_byte[6:0], 1'b0};
                st_q     <= L_RDATA;
              end else if (nxt_q == L_RDATA) begin
                sda_oe_q <= 1'b0;
                scl_oe_q <= 1'b1;
                st_q     <= L_WAIT;
              end else begin
                sda_oe_q <= 1'b0;
                st_q     <= nxt_q;
              end
            end
          end
          L_WAIT: begin
            if (rdv_q) begin
              sda_oe_q <= ~tx_byte[7];
              sh_q     <= {tx_byte[6:0], 1'b0};
              scl_oe_q <= 1'b0;
              st_q     <= L_RDATA;
            end
          end
          L_RDATA: begin
            if (scl_fall) begin
              bcnt_q <= bcnt_q + 4'd1;
              if (bcnt_q == 4'd7) begin
                sda_oe_q <= 1'b0;
                ridx_q   <= ridx_q + {1'b0, ridx_q != 2'd2};
                st_q     <= L_RACK;
              end else begin
                sda_oe_q <= ~sh_q[7];
                sh_q     <= {sh_q[6:0], 1'b0};
              end
            end
          end
          L_RACK: begin
            if (scl_rise) begin
              mack_q <= ~sda_s;
            end else if (scl_fall) begin
              bcnt_q <= '0;
              if (mack_q) begin
                sda_oe_q <= ~tx_byte[7];
                sh_q     <= {tx_byte[6:0], 1'b0};
                st_q     <= L_RDATA;
              end else begin
                st_q <= L_IDLE;
              end
            end
          end
          default: st_q <= L_IDLE;
        endcase
      end
      if (rsp_v) begin
        rdat_q <= rsp_word;
        rdv_q  <= 1'b1;
      end
    end
  end

  assign pmb_sda_oe_o = sda_oe_q;
  assign pmb_scl_oe_o = scl_oe_q;

  // open drain: the level is always low, only the enables move
  logic pin_low_q;
  always_ff @(posedge link_clk_i) begin
    pin_low_q <= 1'b0;
  end
  assign pmb_sda_o = pin_low_q;
  assign pmb_scl_o = pin_low_q;

  // crossings between the link and the register bank
  logic              mreq_v;
  logic [`REQ_W-1:0] mreq;
  logic [`RSP_W-1:0] mrsp;
  wire               rd_v = mreq_v & ~mreq[24];
  wire               wr_v = mreq_v & mreq[24];

  word_handshake #(.W(`REQ_W)) u_req_hs (
    .src_clk_i   (link_clk_i),
    .src_rst_n_i (lrst_n),
    .send_i      (req_send_q),
    .data_i      (req_q),
    .busy_o      (),
    .dst_clk_i   (mclk_i),
    .dst_rst_n_i (nrst_i),
    .valid_o     (mreq_v),
    .data_o      (mreq)
  );

  word_handshake #(.W(`RSP_W)) u_rsp_hs (
    .src_clk_i   (mclk_i),
    .src_rst_n_i (nrst_i),
    .send_i      (rd_v),
    .data_i      (mrsp),
    .busy_o      (),
    .dst_clk_i   (link_clk_i),
    .dst_rst_n_i (lrst_n),
    .valid_o     (rsp_v),
    .data_o      (rsp_word)
  );

  // register bank on mclk_i
  logic [7:0] page_q;
  logic [7:0] ceil_q     [2];
  logic [7:0] applied_q  [2];
  logic [7:0] ov_trip_q  [2];
  logic [7:0] uv_trip_q  [2];
  logic [1:0] ovf_s;
  logic [1:0] uvf_s;
  logic [1:0] en_pin_s;
  logic [1:0] en_q;
  logic       alert_n_q;

  sync_bits #(.W(6)) u_fault_sync (
    .clk_i (mclk_i),
    .d_i   ({ov_fault_i, uv_fault_i, channel_enable_pin_i}),
    .q_o   ({ovf_s, uvf_s, en_pin_s})
  );

  wire [7:0]  wr_cmd   = mreq[23:16];
  wire [1:0]  pmask    = page_mask(page_q);
  wire        rsel     = (pmask == 2'b10);
  wire        wr_page  = wr_v & (wr_cmd == `CMD_PAGE);
  wire [1:0]  wr_ceil  = {2{wr_v & (wr_cmd == `CMD_CEIL)}} & pmask;
  wire [7:0]  tgt [2];
  wire [7:0]  droop [2];
  wire [1:0]  over;
  wire [1:0]  en_now   = en_pin_s & operation_on_i;
  wire [1:0]  en_drop  = en_q & ~en_now;

  assign tgt[0]   = target_code_a_i;
  assign tgt[1]   = target_code_b_i;
  assign droop[0] = droop_code_a_i;
  assign droop[1] = droop_code_b_i;
  assign over     = {target_load_i[1] & (tgt[1] > ceil_q[1]),
                     target_load_i[0] & (tgt[0] > ceil_q[0])};

  // reaction byte is one constant for both channels, page is not looked at
  assign mrsp = (mreq[23:16] == `CMD_PAGE)     ? {8'h00, page_q} :
                (mreq[23:16] == `CMD_CEIL)     ? {8'h00, ceil_q[rsel]} :
                (mreq[23:16] == `CMD_OV_TRIP)  ? {8'h00, ov_trip_q[rsel]} :
                (mreq[23:16] == `CMD_OV_REACT) ? {8'h00, `OV_REACT_CODE} :
                (mreq[23:16] == `CMD_UV_TRIP)  ? {8'h00, uv_trip_q[rsel]} :
                16'h0000;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      page_q <= `PAGE_RESET;
    end else if (wr_page) begin
      page_q <= mreq[7:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    for (int c = 0; c < 2; c++) begin
      if (!nrst_i) begin
        ceil_q[c]    <= `CEIL_RESET;
        applied_q[c] <= `UV_RESET;
        ov_trip_q[c] <= `OV_TRIP_5MV;
        uv_trip_q[c] <= `UV_RESET;
        en_q[c]      <= 1'b0;
      end else begin
        en_q[c] <= en_now[c];
        if (wr_ceil[c]) ceil_q[c] <= mreq[7:0];
        if (target_load_i[c]) applied_q[c] <= over[c] ? ceil_q[c] : tgt[c];
        ov_trip_q[c] <= dac_step_5mv_i ? `OV_TRIP_5MV
                                       : sat_add(ceil_q[c], OV_OFFSET);
        uv_trip_q[c] <= sat_sub(sat_sub(applied_q[c], droop[c]), UV_OFFSET);
      end
    end
  end

  // sticky status: a set in the clearing cycle wins
  wire [1:0] set_ov   = ovf_s;
  wire [1:0] set_uv   = uvf_s;
  wire [1:0] set_warn = over;
  wire [1:0] keep     = ~status_clear_i;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      channel_off_o     <= 2'b00;
      stat_vout_ov_o    <= 2'b00;
      stat_vout_uv_o    <= 2'b00;
      stat_vout_warn_o  <= 2'b00;
      stat_byte_ovf_o   <= 2'b00;
      stat_byte_other_o <= 2'b00;
      stat_word_vout_o  <= 2'b00;
    end else begin
      channel_off_o     <= set_ov | (channel_off_o & ~en_drop);
      stat_vout_ov_o    <= set_ov | (stat_vout_ov_o & keep);
      stat_byte_ovf_o   <= set_ov | (stat_byte_ovf_o & keep);
      stat_vout_uv_o    <= set_uv | (stat_vout_uv_o & keep);
      stat_vout_warn_o  <= set_warn | (stat_vout_warn_o & keep);
      stat_byte_other_o <= set_uv | set_warn | (stat_byte_other_o & keep);
      stat_word_vout_o  <= set_ov | set_uv | set_warn | (stat_word_vout_o & keep);
    end
  end

  wire alert_w = |((stat_vout_ov_o & {2{~mask_ov_i}}) |
                   (stat_vout_uv_o & {2{~mask_uv_i}}) |
                   (stat_vout_warn_o & {2{~mask_warn_i}}));

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) alert_n_q <= 1'b1;
    else         alert_n_q <= ~alert_w;
  end

  assign host_alert_n_o     = alert_n_q;
  assign applied_target_a_o = applied_q[0];
  assign applied_target_b_o = applied_q[1];

endmodule : ovp_regs

// *** ovp_regs_asserts.sv ***
/* Checker of the protection bank: clamp, status, latch-off and alert relations.
   Assumes binding to ovp_regs; every relation is on the mclk_i side. */
`timescale 1ns/1ns
module ovp_regs_asserts (
  // clock and reset
  input wire logic       mclk_i,
  input wire logic       nrst_i,
  // converter side inputs
  input wire logic [7:0] target_code_a_i,
  input wire logic [1:0] target_load_i,
  input wire logic [1:0] ov_fault_i,
  input wire logic [1:0] channel_enable_pin_i,
  input wire logic [1:0] operation_on_i,
  input wire logic       mask_ov_i,
  input wire logic       mask_uv_i,
  input wire logic       mask_warn_i,
  // watched outputs
  input wire logic       host_alert_n_o,
  input wire logic [7:0] applied_target_a_o,
  input wire logic [1:0] channel_off_o,
  input wire logic [1:0] stat_byte_ovf_o,
  input wire logic [1:0] stat_byte_other_o,
  input wire logic [1:0] stat_word_vout_o,
  input wire logic [1:0] stat_vout_ov_o,
  input wire logic [1:0] stat_vout_uv_o,
  input wire logic [1:0] stat_vout_warn_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  logic alert_due;
  assign alert_due = (|stat_vout_ov_o && !mask_ov_i) || (|stat_vout_uv_o && !mask_uv_i)
                     || (|stat_vout_warn_o && !mask_warn_i);

  a_clamp_bound: assert property (target_load_i[0] |=> applied_target_a_o <= $past(target_code_a_i))
    else $error("applied target above commanded target");
  a_clamp_warns: assert property (target_load_i[0] ##1 applied_target_a_o != $past(target_code_a_i)
    |-> stat_vout_warn_o[0] && stat_byte_other_o[0] && stat_word_vout_o[0])
    else $error("clamp without warning status");
  a_ov_status: assert property ($rose(stat_vout_ov_o[0])
    |-> stat_byte_ovf_o[0] && stat_word_vout_o[0] ##[0:1] channel_off_o[0])
    else $error("overvoltage status incomplete or channel not off");
  a_ov_delay: assert property ($rose(ov_fault_i[1]) |-> ##[1:4] stat_vout_ov_o[1])
    else $error("overvoltage status late");
  a_uv_status: assert property ($rose(stat_vout_uv_o[0])
    |-> stat_byte_other_o[0] && stat_word_vout_o[0])
    else $error("undervoltage status incomplete");
  a_alert_raise: assert property (alert_due |=> !host_alert_n_o)
    else $error("alert not raised");
  a_alert_quiet: assert property (!alert_due |=> host_alert_n_o)
    else $error("alert raised while masked or idle");
  a_latch_hold: assert property (
    (channel_off_o[0] && channel_enable_pin_i[0] && operation_on_i[0])[*4] |=> channel_off_o[0])
    else $error("latch-off released while enabled");
endmodule : ovp_regs_asserts

bind ovp_regs ovp_regs_asserts u_asserts (
  .mclk_i, .nrst_i, .target_code_a_i, .target_load_i, .ov_fault_i,
  .channel_enable_pin_i, .operation_on_i, .mask_ov_i, .mask_uv_i, .mask_warn_i,
  .host_alert_n_o, .applied_target_a_o, .channel_off_o, .stat_byte_ovf_o,
  .stat_byte_other_o, .stat_word_vout_o, .stat_vout_ov_o, .stat_vout_uv_o,
  .stat_vout_warn_o
);

// *** ovp_regs_tb_top.sv ***
/* Self-checking bench of the protection register bank.
   Assumes ovp_regs, its checker and pmb_host_model are compiled first. */
`timescale 1ns/1ns
`include "ovp_params.svh"
`define CHK(g, e) check_val(16'(g), 16'(e))
module ovp_regs_tb_top;
  localparam logic [7:0] OVO = 8'h0c;
  localparam logic [7:0] UVO = 8'h05;
  logic        mclk = 1'b0;
  logic        lclk = 1'b0;
  logic        nrst = 1'b0;
  logic        dac5, m_ov, m_uv, m_wn, alert_n, scl_oe, sda_oe, scl_lo, sda_lo, scl_po, sda_po;
  logic [7:0]  tgt_a, tgt_b, drp_a, drp_b, app_a, app_b, c0, c1;
  logic [1:0]  load, ovf, uvf, en, on, clr, off, s_bov, s_oth, s_wv, s_ov, s_uv, s_wn;
  logic [15:0] rd;
  wire         scl = ~scl_lo & (~scl_oe | scl_po);
  wire         sda = ~sda_lo & (~sda_oe | sda_po);
  int          seed = 32'h2b3d8978;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  logic [7:0]  rcmd [5] = '{`CMD_CEIL, `CMD_OV_TRIP, `CMD_UV_TRIP, `CMD_OV_REACT, 8'h30};
  logic [15:0] rexp [5] = '{16'h00ff, 16'h00ff, 16'h0000, 16'h0080, 16'h0000};
  int          rlen [5] = '{2, 2, 2, 1, 2};

  initial forever #50 mclk = ~mclk;
  initial begin
    #2;
    forever #3 lclk = ~lclk;
  end

  ovp_regs #(.OV_OFFSET(OVO), .UV_OFFSET(UVO)) u_dut (
    .mclk_i(mclk), .nrst_i(nrst), .link_clk_i(lclk),
    .pmb_scl_i(scl), .pmb_scl_o(scl_po), .pmb_scl_oe_o(scl_oe),
    .pmb_sda_i(sda), .pmb_sda_o(sda_po), .pmb_sda_oe_o(sda_oe), .host_alert_n_o(alert_n),
    .dac_step_5mv_i(dac5), .target_code_a_i(tgt_a), .target_code_b_i(tgt_b),
    .target_load_i(load), .droop_code_a_i(drp_a), .droop_code_b_i(drp_b),
    .ov_fault_i(ovf), .uv_fault_i(uvf), .channel_enable_pin_i(en), .operation_on_i(on),
    .status_clear_i(clr), .mask_ov_i(m_ov), .mask_uv_i(m_uv), .mask_warn_i(m_wn),
    .applied_target_a_o(app_a), .applied_target_b_o(app_b), .channel_off_o(off),
    .stat_byte_ovf_o(s_bov), .stat_byte_other_o(s_oth), .stat_word_vout_o(s_wv),
    .stat_vout_ov_o(s_ov), .stat_vout_uv_o(s_uv), .stat_vout_warn_o(s_wn)
  );
  pmb_host_model u_host (.scl_i(scl), .sda_i(sda), .scl_low_o(scl_lo), .sda_low_o(sda_lo));

  function automatic logic [7:0] clamp(input logic [7:0] t, input logic [7:0] c);
    return (t > c) ? c : t;
  endfunction : clamp
  function automatic logic [7:0] ov_exp(input logic [7:0] c);
    return (c > 8'hff - OVO) ? 8'hff : c + OVO;
  endfunction : ov_exp
  // droop kept below 20h, so the sum cannot wrap
  function automatic logic [7:0] uv_exp(input logic [7:0] a, input logic [7:0] d);
    return (a < d + UVO) ? 8'h00 : a - d - UVO;
  endfunction : uv_exp

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task automatic test_done(input int t);
    $display("test %0d done", t);
  endtask : test_done
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  task automatic check_pages();
    for (int p = 0; p < 2; p++) begin
      u_host.wr(`CMD_PAGE, 1, 16'(p));
      u_host.rd(`CMD_CEIL, 2, rd);
      `CHK(rd, {8'h00, p ? c1 : c0});
      u_host.rd(`CMD_OV_TRIP, 2, rd);
      `CHK(rd, {8'h00, ov_exp(p ? c1 : c0)});
      u_host.rd(`CMD_OV_REACT, 1, rd);
      `CHK(rd, `OV_REACT_CODE);
    end
  endtask : check_pages

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      finish_test();
    end
  end

  initial begin
    {dac5, m_ov, m_uv, m_wn} = 4'b1000;
    {tgt_a, tgt_b, load, ovf, uvf, clr} = '0;
    drp_a = 8'($random(seed)) & 8'h1f;
    drp_b = 8'($random(seed)) & 8'h1f;
    en = 2'b11;
    on = 2'b11;
    tick(4);
    nrst <= 1'b1;
    tick(10);
    foreach (rcmd[i]) begin
      u_host.rd(rcmd[i], rlen[i], rd);
      `CHK(rd, rexp[i]);
    end
    test_done(1);
    tick(1);
    dac5 <= 1'b0;
    c0 = 8'($random(seed));
    c1 = 8'($random(seed));
    for (int p = 0; p < 2; p++) begin
      u_host.wr(`CMD_PAGE, 1, 16'(p));
      u_host.wr(`CMD_CEIL, 2, {8'h5a, p ? c1 : c0});
    end
    u_host.wr(`CMD_OV_TRIP, 2, 16'h0011);
    check_pages();
    c0 = 8'($random(seed)) | 8'h80;
    c1 = c0;
    u_host.wr(`CMD_PAGE, 1, 16'(`PAGE_ALL));
    u_host.wr(`CMD_CEIL, 2, {8'h00, c0});
    check_pages();
    test_done(2);
    for (int k = 0; k < 24; k++) begin
      tick(1);
      clr <= 2'b11;
      tick(1);
      clr <= 2'b00;
      tgt_a <= (k == 0) ? c0 : (k == 1) ? 8'hff : 8'($random(seed));
      tgt_b <= 8'($random(seed));
      m_wn <= 1'($random(seed));
      load <= 2'b11;
      tick(1);
      load <= 2'b00;
      #1;
      `CHK(app_a, clamp(tgt_a, c0));
      `CHK(app_b, clamp(tgt_b, c1));
      `CHK({s_wn, s_oth, s_wv}, {3{tgt_b > c1, tgt_a > c0}});
      tick(1);
      #1;
      `CHK(alert_n, !((tgt_a > c0 || tgt_b > c1) && !m_wn));
    end
    for (int p = 0; p < 2; p++) begin
      u_host.wr(`CMD_PAGE, 1, 16'(p));
      u_host.rd(`CMD_UV_TRIP, 2, rd);
      `CHK(rd, uv_exp(clamp(p ? tgt_b : tgt_a, c0), p ? drp_b : drp_a));
    end
    test_done(3);
    tick(1);
    m_wn <= 1'b1;
    clr <= 2'b11;
    tick(1);
    clr <= 2'b00;
    ovf <= 2'b01;
    tick(6);
    #1;
    `CHK({off, s_bov, s_wv, s_ov, alert_n}, 9'b01_01_01_01_0);
    ovf <= 2'b00;
    tick(4);
    clr <= 2'b11;
    tick(1);
    clr <= 2'b00;
    m_ov <= 1'b1;
    ovf <= 2'b10;
    tick(6);
    #1;
    `CHK({off, s_ov, alert_n}, 5'b11_10_1);
    tick(1);
    ovf <= 2'b00;
    en <= 2'b10;
    tick(6);
    #1;
    `CHK(off, 2'b10);
    tick(1);
    en <= 2'b11;
    on <= 2'b01;
    tick(6);
    #1;
    `CHK(off, 2'b00);
    tick(1);
    on <= 2'b11;
    clr <= 2'b11;
    tick(1);
    clr <= 2'b00;
    uvf <= 2'b01;
    tick(6);
    #1;
    `CHK({off, s_uv, s_oth, s_wv, alert_n}, 9'b00_01_01_01_0);
    `CHK(u_host.nacks, 0);
    test_done(4);
    finish_test();
  end
endmodule : ovp_regs_tb_top

// *** pmb_host_model.sv ***
/* Bit-level host of the two-wire management link.
   Assumes the bench resolves both open-drain wires; released wires read high. */
`timescale 1ns/1ns
module pmb_host_model #(
  parameter logic [6:0] ADDR = 7'h2a,  // arbitrary, matches the device default
  parameter int         Q    = 250
) (
  // resolved wire levels
  input  wire logic scl_i,
  input  wire logic sda_i,
  // high while the host pulls the wire low
  output logic      scl_low_o,
  output logic      sda_low_o
);
  int nacks = 0;
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  // one clock pulse; waiting on the wire honours clock stretching
  task automatic step(input logic a, input logic b, input logic s, output logic r);
    sda_low_o = a;
    #Q;
    scl_low_o = 1'b0;
    wait (scl_i);
    #Q;
    r = sda_i;
    sda_low_o = b;
    #Q;
    scl_low_o = s;
    #Q;
  endtask : step
  task automatic byte_io(input logic [7:0] tx, input logic nine, output logic [7:0] rx,
                         output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      step(~tx[i], ~tx[i], 1'b1, r);
      rx[i] = r;
    end
    step(~nine, ~nine, 1'b1, r);
    ack = ~r;
  endtask : byte_io
  task automatic snd(input logic [7:0] b);
    logic [7:0] x;
    logic       a;
    byte_io(b, 1'b1, x, a);
    if (!a) nacks++;
  endtask : snd
  task automatic wr(input logic [7:0] cmd, input int n, input logic [15:0] d);
    logic r;
    step(1'b0, 1'b1, 1'b1, r);
    snd({ADDR, 1'b0});
    snd(cmd);
    for (int i = 0; i < n; i++) snd(d[8*i +: 8]);
    step(1'b1, 1'b0, 1'b0, r);
  endtask : wr
  // byte read for the reaction code, word read for the trip levels
  task automatic rd(input logic [7:0] cmd, input int n, output logic [15:0] d);
    logic [7:0] x;
    logic       a;
    d = 16'h0000;
    step(1'b0, 1'b1, 1'b1, a);
    snd({ADDR, 1'b0});
    snd(cmd);
    step(1'b0, 1'b1, 1'b1, a);
    snd({ADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      byte_io(8'hff, 1'(i == n - 1), x, a);
      d[8*i +: 8] = x;
    end
    step(1'b1, 1'b0, 1'b0, a);
  endtask : rd
endmodule : pmb_host_model

// *** sync_bits.sv ***
/*
  Two-flop synchroniser for a group of independent levels.
  Assumes each bit is a level that stays put for several destination clocks.
*/
`timescale 1ns/1ns
module sync_bits #(
  parameter int W = 1
) (
  // destination clock
  input  wire logic         clk_i,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // no reset: the reset itself passes through this cell
  always_ff @(posedge clk_i) begin
    meta_q <= d_i;
    q_o    <= meta_q;
  end

endmodule : sync_bits

// *** word_handshake.sv ***
/*
  Toggle handshake carrying one word from a source clock to a destination clock.
  Assumes the source sends only while busy_o is low; a send while busy is dropped.
*/
`timescale 1ns/1ns
module word_handshake #(
  parameter int W = 8
) (
  // source side
  input  wire logic         src_clk_i,
  input  wire logic         src_rst_n_i,
  input  wire logic         send_i,
  input  wire logic [W-1:0] data_i,
  output logic              busy_o,
  // destination side
  input  wire logic         dst_clk_i,
  input  wire logic         dst_rst_n_i,
  output logic              valid_o,
  output logic      [W-1:0] data_o
);

  logic [W-1:0] hold_q;
  logic         req_q;
  logic         ack_q;
  logic         req_s;
  logic         ack_s;

  sync_bits #(.W(1)) u_req_sync (.clk_i(dst_clk_i), .d_i(req_q), .q_o(req_s));
  sync_bits #(.W(1)) u_ack_sync (.clk_i(src_clk_i), .d_i(ack_q), .q_o(ack_s));

  assign busy_o = req_q ^ ack_s;

  // hold_q stays still until the acknowledge returns, so the far side may read it
  always_ff @(posedge src_clk_i) begin
    if (!src_rst_n_i) begin
      hold_q <= '0;
      req_q  <= 1'b0;
    end else if (send_i && !busy_o) begin
      hold_q <= data_i;
      req_q  <= ~req_q;
    end
  end

  always_ff @(posedge dst_clk_i) begin
    if (!dst_rst_n_i) begin
      ack_q   <= 1'b0;
      valid_o <= 1'b0;
      data_o  <= '0;
    end else begin
      valid_o <= req_s ^ ack_q;
      if (req_s ^ ack_q) begin
        data_o <= hold_q;
        ack_q  <= req_s;
      end
    end
  end

endmodule : word_handshake
